// [dv/tb_iowdt_top.sv]
// Self-checking testbench of the I/O port watchdog.
`timescale 1ns/1ps
`default_nettype none
module tb_iowdt_top;
  import iowdt_pkg::*;
  // A short tick keeps the full 255 second case affordable.
  localparam int TC = 20;
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [15:0] i_io_addr = 16'h0000;
  logic [7:0] i_io_wdata = 8'h00;
  logic i_io_wr = 1'b0;
  logic i_io_rd = 1'b0;
  logic o_sys_reset, o_nmi, o_irq10, o_irq11, o_irq15, o_running;
  logic [7:0] o_remaining;
  int errors = 0;
  int num_checks = 0;
  wire [4:0] lines = {o_sys_reset, o_nmi, o_irq10, o_irq11, o_irq15};
  iowdt_top #(.TICK_CYCLES(TC)) u_dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_io_addr(i_io_addr),
    .i_io_wdata(i_io_wdata), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .o_sys_reset(o_sys_reset), .o_nmi(o_nmi),
    .o_irq10(o_irq10), .o_irq11(o_irq11), .o_irq15(o_irq15), .o_running(o_running), .o_remaining(o_remaining));
  initial begin
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One port access: strobe raised for exactly one cycle, set up on the falling edge.
  task automatic io(input logic [15:0] a, input logic [7:0] d, input logic rd);
    @(negedge i_ref_clk);
    i_io_addr = a;
    i_io_wdata = d;
    i_io_wr = !rd;
    i_io_rd = rd;
    @(negedge i_ref_clk);
    i_io_wr = 1'b0;
    i_io_rd = 1'b0;
  endtask
  task automatic wait_fire(input int lim, output int n);
    n = 0;
    while (lines === 5'h00 && n < lim) begin
      @(negedge i_ref_clk);
      n++;
    end
  endtask
  task automatic expire_case(input logic [2:0] act, input logic [7:0] sec);
    int n;
    io(IOWDT_ACTION_ADDR, {5'h00, act}, 1'b0);
    io(IOWDT_INTERVAL_ADDR, sec, 1'b0);
    @(negedge i_ref_clk);
    chk(o_remaining, sec);
    wait_fire(sec * TC + 10, n);
    chk(8'(n >= sec * TC - 3 && n <= sec * TC + 5), 8'h01);
    chk({3'h0, lines}, {3'h0, 5'h10 >> act});
    chk({7'h00, o_running}, 8'h00);
    io(IOWDT_DISABLE_ADDR, 8'h00, 1'b1);
    repeat (20) @(negedge i_ref_clk);
    chk({3'h0, lines}, 8'h00);
  endtask
  task automatic refresh_case();
    int n;
    io(IOWDT_INTERVAL_ADDR, 8'h03, 1'b0);
    repeat (2 * TC + TC / 2) @(negedge i_ref_clk);
    chk(o_remaining, 8'h01);
    io(IOWDT_INTERVAL_ADDR, 8'h03, 1'b0);
    wait_fire(4 * TC, n);
    chk(8'(n >= 3 * TC - 3 && n <= 3 * TC + 5), 8'h01);
    chk({3'h0, lines}, 8'h01);
    io(IOWDT_DISABLE_ADDR, 8'h00, 1'b1);
    repeat (20) @(negedge i_ref_clk);
  endtask
  task automatic stop_case();
    int n;
    io(IOWDT_INTERVAL_ADDR, 8'h02, 1'b0);
    repeat (TC) @(negedge i_ref_clk);
    io(IOWDT_DISABLE_ADDR, 8'h00, 1'b1);
    wait_fire(3 * TC, n);
    chk({3'h0, lines}, 8'h00);
    chk({7'h00, o_running}, 8'h00);
    // After an unmapped write, a zero interval must stop the count that the interval 5 write started.
    io(16'h0445, 8'h01, 1'b0);
    io(IOWDT_INTERVAL_ADDR, 8'h05, 1'b0);
    chk({7'h00, o_running}, 8'h01);
    io(IOWDT_INTERVAL_ADDR, 8'h00, 1'b0);
    repeat (3) @(negedge i_ref_clk);
    chk({7'h00, o_running}, 8'h00);
  endtask
  // Codes above the last line fire silently; the unmapped write must not turn code 5 into a line.
  task automatic unused_code_case();
    io(IOWDT_ACTION_ADDR, 8'h05, 1'b0);
    io(16'h0445, 8'h01, 1'b0);
    io(IOWDT_INTERVAL_ADDR, 8'h01, 1'b0);
    chk({7'h00, o_running}, 8'h01);
    repeat (TC + 5) @(negedge i_ref_clk);
    chk({o_running, 2'h0, lines}, 8'h00);
    io(IOWDT_DISABLE_ADDR, 8'h00, 1'b1);
  endtask
  // A reset in mid-count clears the count and returns the action to system reset.
  task automatic reset_case();
    int n;
    io(IOWDT_ACTION_ADDR, {5'h00, IOWDT_ACT_IRQ10}, 1'b0);
    io(IOWDT_INTERVAL_ADDR, 8'h02, 1'b0);
    repeat (TC / 2) @(negedge i_ref_clk);
    i_resetn = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    i_resetn = 1'b1;
    @(negedge i_ref_clk);
    chk({o_running, 2'h0, lines}, 8'h00);
    chk(o_remaining, 8'h00);
    repeat (3 * TC) @(negedge i_ref_clk);
    chk({o_running, 2'h0, lines}, 8'h00);
    io(IOWDT_INTERVAL_ADDR, 8'h01, 1'b0);
    wait_fire(TC + 10, n);
    chk({3'h0, lines}, 8'h10);
    io(IOWDT_DISABLE_ADDR, 8'h00, 1'b1);
    repeat (20) @(negedge i_ref_clk);
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #240000;
    errors++;
    final_report();
  end
  initial begin
    repeat (10) @(negedge i_ref_clk);
    i_resetn = 1'b1;
    @(negedge i_ref_clk);
    chk({o_running, 2'h0, lines}, 8'h00);
    for (int a = 0; a < 5; a++) begin
      expire_case(3'(a), 8'(a % 2 + 1));
    end
    expire_case(IOWDT_ACT_IRQ15, 8'hff);
    refresh_case();
    stop_case();
    unused_code_case();
    reset_case();
    final_report();
  end
endmodule
`default_nettype wire

// [pkg/iowdt_pkg.sv]
// Package with port addresses, codes and timing constants of the I/O port watchdog.
package iowdt_pkg;
  localparam logic [15:0] IOWDT_DISABLE_ADDR = 16'h0080;
  localparam logic [15:0] IOWDT_INTERVAL_ADDR = 16'h0443;
  localparam logic [15:0] IOWDT_ACTION_ADDR = 16'h0444;
  localparam logic [2:0] IOWDT_ACT_RESET = 3'h0;
  localparam logic [2:0] IOWDT_ACT_NMI = 3'h1;
  localparam logic [2:0] IOWDT_ACT_IRQ10 = 3'h2;
  localparam logic [2:0] IOWDT_ACT_IRQ11 = 3'h3;
  localparam logic [2:0] IOWDT_ACT_IRQ15 = 3'h4;
  localparam logic [2:0] IOWDT_ACTION_RESET_VALUE = 3'h0;
  localparam logic [7:0] IOWDT_INTERVAL_RESET_VALUE = 8'h00;
  localparam int IOWDT_CLK_HZ = 50000000;
  localparam int IOWDT_TICK_S = 1;
  localparam int IOWDT_TICK_CYCLES = IOWDT_CLK_HZ * IOWDT_TICK_S;
  localparam int IOWDT_RESET_PULSE_CYCLES = 16;
  typedef enum logic [1:0] {
    IOWDT_IDLE = 2'b00,
    IOWDT_RUN = 2'b01,
    IOWDT_FIRED = 2'b11
  } iowdt_state_type;
endpackage

// [verilog/iowdt_prescaler.sv]
// One-second tick generator for the I/O port watchdog.
`timescale 1ns/1ps
`default_nettype none
module iowdt_prescaler import iowdt_pkg::*; #(
  parameter int TICK_CYCLES = IOWDT_TICK_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_restart,
  output logic o_tick
);
  logic [25:0] count;
  wire last = (count == 26'(TICK_CYCLES - 1));
  // Restart aligns the first second to the interval write, so the first expiry is never short.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn || i_restart || last) begin
      count <= 26'h0;
    end else begin
      count <= count + 26'h1;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= last && !i_restart;
    end
  end
endmodule
`default_nettype wire

// [verilog/iowdt_top.sv]
// Top of the I/O port watchdog: port decode, countdown and timeout response.
`timescale 1ns/1ps
`default_nettype none
module iowdt_top import iowdt_pkg::*; #(
  parameter int TICK_CYCLES = IOWDT_TICK_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [15:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  output logic o_sys_reset,
  output logic o_nmi,
  output logic o_irq10,
  output logic o_irq11,
  output logic o_irq15,
  output logic o_running,
  output logic [7:0] o_remaining
);
  iowdt_state_type state;
  iowdt_state_type next_state;
  logic [2:0] action;
  logic [7:0] remaining;
  logic [4:0] rst_cnt;
  logic tick;

  // Full 16-bit compare: a partial decode would alias the ports onto neighbouring addresses.
  function automatic logic port_hit(input logic [15:0] addr, input logic [15:0] port);
    return addr == port;
  endfunction

  function automatic logic action_is(input logic [2:0] act, input logic [2:0] code);
    return act == code;
  endfunction

  wire wr_interval = i_io_wr && port_hit(i_io_addr, IOWDT_INTERVAL_ADDR);
  wire wr_action = i_io_wr && port_hit(i_io_addr, IOWDT_ACTION_ADDR);
  wire rd_disable = i_io_rd && port_hit(i_io_addr, IOWDT_DISABLE_ADDR);
  wire load_ok = wr_interval && (i_io_wdata != 8'h00);
  wire expire = (state == IOWDT_RUN) && tick && (remaining == 8'h01);
  wire fire_reset = expire && action_is(action, IOWDT_ACT_RESET);
  wire start_pulse = fire_reset && !wr_interval && !rd_disable;
  wire count_step = (state == IOWDT_RUN) && tick && (remaining != 8'h00);

  iowdt_prescaler #(.TICK_CYCLES(TICK_CYCLES)) u_prescaler (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_restart(wr_interval),
    .o_tick(tick)
  );

  // A disable read wins over a write in the same cycle; zero interval is taken as stop.
  always_comb begin
    next_state = state;
    case (state)
      IOWDT_IDLE: begin
        if (load_ok && !rd_disable) begin
          next_state = IOWDT_RUN;
        end
      end
      IOWDT_RUN: begin
        if (rd_disable || (wr_interval && !load_ok)) begin
          next_state = IOWDT_IDLE;
        end else if (expire && !wr_interval) begin
          next_state = IOWDT_FIRED;
        end
      end
      IOWDT_FIRED: begin
        if (rd_disable) begin
          next_state = IOWDT_IDLE;
        end else if (load_ok) begin
          next_state = IOWDT_RUN;
        end else if (wr_interval) begin
          next_state = IOWDT_IDLE;
        end
      end
      default: begin
        next_state = IOWDT_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      state <= IOWDT_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      action <= IOWDT_ACTION_RESET_VALUE;
    end else if (wr_action) begin
      action <= i_io_wdata[2:0];
    end
  end

  // Load beats the tick, so a refresh landing on a second boundary is never lost.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      remaining <= IOWDT_INTERVAL_RESET_VALUE;
    end else if (wr_interval) begin
      remaining <= i_io_wdata;
    end else if (count_step) begin
      remaining <= remaining - 8'h01;
    end
  end

  // The system reset is a fixed-length pulse; held interrupt levels stay until software reacts.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      rst_cnt <= 5'h00;
      o_sys_reset <= 1'b0;
    end else begin
      if (start_pulse) begin
        rst_cnt <= 5'(IOWDT_RESET_PULSE_CYCLES);
      end else if (rst_cnt != 5'h00) begin
        rst_cnt <= rst_cnt - 5'h01;
      end
      o_sys_reset <= (rst_cnt != 5'h00);
    end
  end

  wire next_fired = (next_state == IOWDT_FIRED);
  wire next_running = (next_state == IOWDT_RUN);
  wire next_nmi = next_fired && action_is(action, IOWDT_ACT_NMI);
  wire next_irq10 = next_fired && action_is(action, IOWDT_ACT_IRQ10);
  wire next_irq11 = next_fired && action_is(action, IOWDT_ACT_IRQ11);
  wire next_irq15 = next_fired && action_is(action, IOWDT_ACT_IRQ15);
  // Codes 5 to 7 match no line: the state still fires, but nothing reaches the processor.
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_nmi <= 1'b0;
      o_irq10 <= 1'b0;
      o_irq11 <= 1'b0;
      o_irq15 <= 1'b0;
      o_running <= 1'b0;
      o_remaining <= 8'h00;
    end else begin
      o_nmi <= next_nmi;
      o_irq10 <= next_irq10;
      o_irq11 <= next_irq11;
      o_irq15 <= next_irq15;
      o_running <= next_running;
      o_remaining <= remaining;
    end
  end

  // Checks.
  AST_ACTION_STORED: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    wr_action |=> (action == $past(i_io_wdata[2:0])))
    else $error("action select not stored");
  AST_RESET_PULSE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (fire_reset && !wr_interval && !rd_disable) |=> ##1 o_sys_reset [*8])
    else $error("system reset pulse missing");
  AST_IRQ_RAISED: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (expire && !wr_interval && !rd_disable && action == IOWDT_ACT_IRQ11) |=> o_irq11)
    else $error("irq11 not raised on expiry");
  AST_LOAD_VALUE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    wr_interval |=> (remaining == $past(i_io_wdata)))
    else $error("interval not loaded");
  AST_ONE_PER_TICK: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (!tick && !wr_interval) |=> (remaining == $past(remaining)))
    else $error("count moved without a tick");
  AST_REFRESH_RUN: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (load_ok && !rd_disable) |=> (state == IOWDT_RUN) && !o_nmi && !o_irq10)
    else $error("refresh did not restart countdown");
  AST_DISABLE_STOPS: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (rd_disable && !wr_interval) |=> (state == IOWDT_IDLE) ##1 !o_nmi && !o_irq15)
    else $error("disable read did not stop watchdog");
  AST_IDLE_NO_FIRE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (state == IOWDT_IDLE && !load_ok) |=> (state == IOWDT_IDLE))
    else $error("watchdog left idle without interval write");
  AST_RESET_ENDS: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    start_pulse |=> ##1 o_sys_reset [*8] ##1 o_sys_reset [*8] ##1 !o_sys_reset)
    else $error("system reset pulse length wrong");
  AST_EXPIRE_NMI: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (expire && !wr_interval && !rd_disable && action == IOWDT_ACT_NMI) |=> o_nmi)
    else $error("nmi not raised on expiry");
  AST_EXPIRE_IRQ10: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (expire && !wr_interval && !rd_disable && action == IOWDT_ACT_IRQ10) |=> o_irq10)
    else $error("irq10 not raised on expiry");
  AST_EXPIRE_IRQ15: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (expire && !wr_interval && !rd_disable && action == IOWDT_ACT_IRQ15) |=> o_irq15)
    else $error("irq15 not raised on expiry");
  AST_UNUSED_SILENT: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (expire && !wr_interval && !rd_disable && action > IOWDT_ACT_IRQ15) |=>
    (state == IOWDT_FIRED) && !o_nmi && !o_irq10 && !o_irq11 && !o_irq15)
    else $error("unused action code raised a line");
  AST_LINES_ONEHOT: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    $onehot0({o_nmi, o_irq10, o_irq11, o_irq15}))
    else $error("more than one interrupt line high");
  AST_IRQ_HELD: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (o_irq10 && !rd_disable && !wr_interval && !wr_action) |=> o_irq10)
    else $error("irq10 dropped without software action");
  AST_LINES_NEED_FIRE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (o_nmi || o_irq10 || o_irq11 || o_irq15) |-> (state == IOWDT_FIRED))
    else $error("interrupt line high outside fired state");
  AST_ZERO_STOPS: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (wr_interval && !load_ok) |=> (state == IOWDT_IDLE))
    else $error("zero interval did not stop watchdog");
  AST_DECREMENT: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (count_step && !wr_interval) |=> (remaining == $past(remaining) - 8'h01))
    else $error("count did not step down on tick");
  AST_ACTION_KEPT: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    !wr_action |=> $stable(action))
    else $error("action changed without a write");
  AST_REMAINING_COPY: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    1'b1 |=> (o_remaining == $past(remaining)))
    else $error("remaining output does not follow count");
  AST_RUN_OUTPUT: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    o_running == (state == IOWDT_RUN))
    else $error("running output does not match state");
  AST_IDLE_QUIET: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (state == IOWDT_IDLE) |-> !o_running && !o_nmi && !o_irq10 && !o_irq11 && !o_irq15)
    else $error("output active while idle");

  // Main scenarios reached by the bench.
  COV_FIRE_RESET: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) fire_reset);
  COV_FIRE_NMI: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) o_nmi);
  COV_REFRESH: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) (state == IOWDT_RUN) && load_ok);
  COV_DISABLE: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) (state == IOWDT_RUN) && rd_disable);
  COV_UNUSED_CODE: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) expire && (action > IOWDT_ACT_IRQ15));
endmodule
`default_nettype wire
